// *** hdl/sync_sel_pkg.sv ***
// constants and types of the sync source selector
package sync_sel_pkg;

    typedef enum logic [3:0] {
        free_running_oscillator_mode = 4'h0,
        extended_oscillator_mode     = 4'h1,
        satellite_single_mode        = 4'h2,
        radio_pulse_single_mode      = 4'h3,
        serial_string_single_mode    = 4'h4,
        radio_signal_single_mode     = 4'h5,
        satellite_safety_mode        = 4'h6,
        radio_pulse_safety_mode      = 4'h7,
        radio_signal_safety_mode     = 4'h8,
        satellite_multi_mode         = 4'h9,
        radio_pulse_multi_mode       = 4'hA
    } mode_t;

    typedef enum logic [1:0] {
        src_none      = 2'h0,
        src_satellite = 2'h1,
        src_radio     = 2'h2,
        src_serial    = 2'h3
    } src_t;

    typedef enum logic [1:0] {
        stat_invalid = 2'h0,
        stat_quartz  = 2'h1,
        stat_sync    = 2'h2
    } stat_t;

    // display identifiers
    typedef enum logic [3:0] {
        disp_free_running   = 4'h0,
        disp_satellite      = 4'h1,
        disp_radio_pulse    = 4'h2,
        disp_serial_string  = 4'h3,
        disp_satellite_safe = 4'h4,
        disp_radio_safe     = 4'h5,
        disp_tag_satellite  = 4'h6,
        disp_tag_radio      = 4'h7,
        disp_tag_serial     = 4'h8
    } disp_t;

    localparam int          QUARTZ_W        = 16;
    localparam logic [15:0] QUARTZ_RESET    = 16'h8000;
    localparam int          INFO_W          = 32;
    localparam int          TIME_W          = 32;
    localparam int          SRC_TIMEOUT_MS  = 2000;
    localparam int          CLK_KHZ         = 200000;
    localparam int          SRC_TIMEOUT_CYC = SRC_TIMEOUT_MS * CLK_KHZ;
    localparam int          ALT_PERIOD_MS   = 1000;
    localparam int          ALT_PERIOD_CYC  = ALT_PERIOD_MS * CLK_KHZ;

endpackage

// *** hdl/src_monitor.sv ***
// one source monitor: sync, liveness and status class
`timescale 1ns/10ps
module src_monitor #(
    parameter int TIMEOUT = sync_sel_pkg::SRC_TIMEOUT_CYC
) (
    input  wire logic                     i_ref_clk,
    input  wire logic                     i_resetn,
    input  wire logic                     i_event,
    input  wire logic                     i_locked,
    output sync_sel_pkg::stat_t           o_status,
    output logic                          o_event
);
    logic       meta;
    logic       sync;
    logic       last;
    logic [31:0] age;

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            meta <= 1'b0;
            sync <= 1'b0;
            last <= 1'b0;
        end else begin
            meta <= i_event;
            sync <= meta;
            last <= sync;
        end
    end

    assign o_event = sync & ~last;

    // age since last event
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            age <= 32'(TIMEOUT);
        end else if (o_event) begin
            age <= 32'h0;
        end else if (age < 32'(TIMEOUT)) begin
            age <= age + 32'h1;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_status <= sync_sel_pkg::stat_invalid;
        end else if (age >= 32'(TIMEOUT)) begin
            o_status <= sync_sel_pkg::stat_invalid;
        end else if (i_locked) begin
            o_status <= sync_sel_pkg::stat_sync;
        end else begin
            o_status <= sync_sel_pkg::stat_quartz;
        end
    end
endmodule

// *** hdl/sync_source_selector.sv ***
// sync source selector top
`timescale 1ns/10ps
module sync_source_selector #(
    parameter int TIMEOUT = sync_sel_pkg::SRC_TIMEOUT_CYC,
    parameter int ALT_CYC = sync_sel_pkg::ALT_PERIOD_CYC
) (
    input  wire logic                              i_ref_clk,
    input  wire logic                              i_resetn,
    input  wire logic [3:0]                        i_mode,
    input  wire logic                              i_mode_load,
    input  wire logic                              i_serial_primary,
    input  wire logic [sync_sel_pkg::QUARTZ_W-1:0] i_quartz_value,
    input  wire logic                              i_quartz_load,
    input  wire logic                              i_sat_event,
    input  wire logic                              i_sat_locked,
    input  wire logic [sync_sel_pkg::TIME_W-1:0]   i_sat_time,
    input  wire logic [sync_sel_pkg::INFO_W-1:0]   i_sat_info,
    input  wire logic                              i_radio_pulse,
    input  wire logic                              i_radio_locked,
    input  wire logic [sync_sel_pkg::TIME_W-1:0]   i_radio_time,
    input  wire logic [sync_sel_pkg::INFO_W-1:0]   i_radio_info,
    input  wire logic                              i_serial_event,
    input  wire logic                              i_serial_locked,
    input  wire logic [sync_sel_pkg::TIME_W-1:0]   i_serial_time,
    input  wire logic [sync_sel_pkg::INFO_W-1:0]   i_serial_info,
    output sync_sel_pkg::mode_t                    o_mode,
    output logic                                   o_mode_refused,
    output logic [sync_sel_pkg::QUARTZ_W-1:0]      o_quartz_value,
    output sync_sel_pkg::src_t                     o_active_src,
    output logic                                   o_sync_pulse,
    output logic [sync_sel_pkg::TIME_W-1:0]        o_sync_time,
    output logic                                   o_discipline,
    output logic                                   o_free_running,
    output logic                                   o_mismatch,
    output sync_sel_pkg::disp_t                    o_disp_id,
    output logic                                   o_disp_primary_mark,
    output sync_sel_pkg::stat_t                    o_sat_status,
    output sync_sel_pkg::stat_t                    o_radio_status,
    output sync_sel_pkg::stat_t                    o_serial_status
);
    ////////////////////////////////////////////////////////////////////////
    sync_sel_pkg::mode_t mode;
    sync_sel_pkg::src_t  primary;
    sync_sel_pkg::src_t  secondary;
    sync_sel_pkg::src_t  next_src;
    sync_sel_pkg::stat_t sat_st;
    sync_sel_pkg::stat_t rad_st;
    sync_sel_pkg::stat_t ser_st;
    logic                sat_ev;
    logic                rad_ev;
    logic                ser_ev;
    logic                safety;
    logic                multi;
    logic                agree;
    logic                trig;
    logic [31:0]         alt_cnt;
    logic                alt_phase;

    src_monitor #(.TIMEOUT(TIMEOUT)) u_sat (
        .i_ref_clk (i_ref_clk),
        .i_resetn  (i_resetn),
        .i_event   (i_sat_event),
        .i_locked  (i_sat_locked),
        .o_status  (sat_st),
        .o_event   (sat_ev)
    );
    src_monitor #(.TIMEOUT(TIMEOUT)) u_radio (
        .i_ref_clk (i_ref_clk),
        .i_resetn  (i_resetn),
        .i_event   (i_radio_pulse),
        .i_locked  (i_radio_locked),
        .o_status  (rad_st),
        .o_event   (rad_ev)
    );
    src_monitor #(.TIMEOUT(TIMEOUT)) u_serial (
        .i_ref_clk (i_ref_clk),
        .i_resetn  (i_resetn),
        .i_event   (i_serial_event),
        .i_locked  (i_serial_locked),
        .o_status  (ser_st),
        .o_event   (ser_ev)
    );

    assign o_sat_status    = sat_st;
    assign o_radio_status  = rad_st;
    assign o_serial_status = ser_st;

    ////////////////////////////////////////////////////////////////////////
    // mode selection
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            mode           <= sync_sel_pkg::free_running_oscillator_mode;
            o_mode_refused <= 1'b0;
        end else if (i_mode_load) begin
            case (i_mode)
                4'h1, 4'h5, 4'h8: o_mode_refused <= 1'b1;
                4'h0, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h9, 4'hA: begin
                    mode           <= sync_sel_pkg::mode_t'(i_mode);
                    o_mode_refused <= 1'b0;
                end
                default: o_mode_refused <= 1'b1;
            endcase
        end
    end
    assign o_mode = mode;

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_quartz_value <= sync_sel_pkg::QUARTZ_RESET;
        end else if (i_quartz_load) begin
            o_quartz_value <= i_quartz_value;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // safety pairings / multi pairings
    assign safety = (mode == sync_sel_pkg::satellite_safety_mode) ||
                    (mode == sync_sel_pkg::radio_pulse_safety_mode);
    assign multi  = (mode == sync_sel_pkg::satellite_multi_mode) ||
                    (mode == sync_sel_pkg::radio_pulse_multi_mode);

    always_comb begin
        sync_sel_pkg::src_t other;
        other = (mode == sync_sel_pkg::satellite_multi_mode) ? sync_sel_pkg::src_satellite
                                                             : sync_sel_pkg::src_radio;
        primary   = i_serial_primary ? sync_sel_pkg::src_serial : other;
        secondary = i_serial_primary ? other : sync_sel_pkg::src_serial;
    end

    function automatic sync_sel_pkg::stat_t st_of(input sync_sel_pkg::src_t s,
                                                  input sync_sel_pkg::stat_t a,
                                                  input sync_sel_pkg::stat_t b,
                                                  input sync_sel_pkg::stat_t c);
        case (s)
            sync_sel_pkg::src_satellite: st_of = a;
            sync_sel_pkg::src_radio:     st_of = b;
            sync_sel_pkg::src_serial:    st_of = c;
            default:                     st_of = sync_sel_pkg::stat_invalid;
        endcase
    endfunction

    always_comb begin
        if (mode == sync_sel_pkg::satellite_safety_mode) begin
            agree = (i_sat_time == i_serial_time) && (i_sat_info == i_serial_info);
        end else begin
            agree = (i_radio_time == i_serial_time) && (i_radio_info == i_serial_info);
        end
    end

    // source choice per mode
    always_comb begin
        next_src = sync_sel_pkg::src_none;
        case (mode)
            sync_sel_pkg::free_running_oscillator_mode: next_src = sync_sel_pkg::src_none;
            sync_sel_pkg::satellite_single_mode:
                if (sat_st == sync_sel_pkg::stat_sync) next_src = sync_sel_pkg::src_satellite;
            sync_sel_pkg::radio_pulse_single_mode:
                if (rad_st == sync_sel_pkg::stat_sync) next_src = sync_sel_pkg::src_radio;
            sync_sel_pkg::serial_string_single_mode:
                if (ser_st == sync_sel_pkg::stat_sync) next_src = sync_sel_pkg::src_serial;
            sync_sel_pkg::satellite_safety_mode:
                if (sat_st == sync_sel_pkg::stat_sync && ser_st == sync_sel_pkg::stat_sync)
                    next_src = sync_sel_pkg::src_serial;
            sync_sel_pkg::radio_pulse_safety_mode:
                if (rad_st == sync_sel_pkg::stat_sync && ser_st == sync_sel_pkg::stat_sync)
                    next_src = sync_sel_pkg::src_serial;
            sync_sel_pkg::satellite_multi_mode, sync_sel_pkg::radio_pulse_multi_mode: begin
                // keep primary / fall back to synced secondary
                if (st_of(primary, sat_st, rad_st, ser_st) == sync_sel_pkg::stat_sync)
                    next_src = primary;
                else if (st_of(secondary, sat_st, rad_st, ser_st) == sync_sel_pkg::stat_sync)
                    next_src = secondary;
            end
            default: next_src = sync_sel_pkg::src_none;
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_active_src <= sync_sel_pkg::src_none;
        end else begin
            o_active_src <= next_src;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // time taken on the active source's event
    always_comb begin
        case (o_active_src)
            sync_sel_pkg::src_satellite: trig = sat_ev;
            sync_sel_pkg::src_radio:     trig = rad_ev;
            sync_sel_pkg::src_serial:    trig = ser_ev;
            default:                     trig = 1'b0;
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_sync_pulse <= 1'b0;
            o_sync_time  <= '0;
            o_mismatch   <= 1'b0;
        end else begin
            o_sync_pulse <= 1'b0;
            if (trig) begin
                if (safety && !agree) begin
                    o_mismatch <= 1'b1;
                end else begin
                    o_mismatch   <= 1'b0;
                    o_sync_pulse <= 1'b1;
                    case (o_active_src)
                        sync_sel_pkg::src_satellite: o_sync_time <= i_sat_time;
                        sync_sel_pkg::src_radio:     o_sync_time <= i_radio_time;
                        default:                     o_sync_time <= i_serial_time;
                    endcase
                end
            end
        end
    end

    // free run on last quartz value when no source
    assign o_discipline   = (o_active_src != sync_sel_pkg::src_none) && !(safety && !agree);
    assign o_free_running = !o_discipline;

    ////////////////////////////////////////////////////////////////////////
    // alternating display
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            alt_cnt   <= 32'h0;
            alt_phase <= 1'b0;
        end else if (alt_cnt >= 32'(ALT_CYC - 1)) begin
            alt_cnt   <= 32'h0;
            alt_phase <= ~alt_phase;
        end else begin
            alt_cnt <= alt_cnt + 32'h1;
        end
    end

    function automatic sync_sel_pkg::disp_t tag_of(input sync_sel_pkg::src_t s);
        case (s)
            sync_sel_pkg::src_satellite: tag_of = sync_sel_pkg::disp_tag_satellite;
            sync_sel_pkg::src_radio:     tag_of = sync_sel_pkg::disp_tag_radio;
            default:                     tag_of = sync_sel_pkg::disp_tag_serial;
        endcase
    endfunction

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_disp_id           <= sync_sel_pkg::disp_free_running;
            o_disp_primary_mark <= 1'b0;
        end else begin
            o_disp_primary_mark <= multi && !alt_phase;
            case (mode)
                sync_sel_pkg::satellite_single_mode:     o_disp_id <= sync_sel_pkg::disp_satellite;
                sync_sel_pkg::radio_pulse_single_mode:   o_disp_id <= sync_sel_pkg::disp_radio_pulse;
                sync_sel_pkg::serial_string_single_mode: o_disp_id <= sync_sel_pkg::disp_serial_string;
                sync_sel_pkg::satellite_safety_mode:     o_disp_id <= sync_sel_pkg::disp_satellite_safe;
                sync_sel_pkg::radio_pulse_safety_mode:   o_disp_id <= sync_sel_pkg::disp_radio_safe;
                sync_sel_pkg::satellite_multi_mode, sync_sel_pkg::radio_pulse_multi_mode:
                    o_disp_id <= alt_phase ? tag_of(secondary) : tag_of(primary);
                default:                                 o_disp_id <= sync_sel_pkg::disp_free_running;
            endcase
        end
    end
endmodule

// *** verif/src_model.sv ***
// behavioural time source feeding one event line
`timescale 1ns/10ps
module src_model (
    input  wire logic        i_ref_clk,
    input  wire logic        i_resetn,
    input  wire logic        i_run,
    input  wire logic        i_lock,
    input  wire logic        i_tick,
    input  wire logic [31:0] i_time,
    input  wire logic [31:0] i_info,
    output logic             o_event,
    output logic             o_locked,
    output logic [31:0]      o_time,
    output logic [31:0]      o_info
);
    logic [2:0] hold;
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            hold   <= 3'h0;
            o_time <= 32'h0;
            o_info <= 32'h0;
        end else if (i_run && i_tick) begin
            hold   <= 3'h4;
            o_time <= i_time;
            o_info <= i_info;
        end else begin
            hold   <= (hold != 3'h0) ? hold - 3'h1 : 3'h0;
            o_time <= i_run ? o_time : ~o_time;
            o_info <= i_run ? o_info : ~o_info;
        end
    end
    assign o_event  = (hold != 3'h0);
    assign o_locked = i_run && i_lock;
endmodule

// *** verif/sync_source_selector_asserts.sv ***
// concurrent checks on the selector ports
`timescale 1ns/10ps
module sync_source_selector_asserts (
    input wire logic                i_ref_clk,
    input wire logic                i_resetn,
    input wire logic [3:0]          i_mode,
    input wire logic                i_mode_load,
    input wire logic                i_serial_primary,
    input wire logic [15:0]         i_quartz_value,
    input wire logic                i_quartz_load,
    input wire logic [31:0]         i_serial_time,
    input wire sync_sel_pkg::mode_t o_mode,
    input wire logic                o_mode_refused,
    input wire logic [15:0]         o_quartz_value,
    input wire sync_sel_pkg::src_t  o_active_src,
    input wire logic                o_sync_pulse,
    input wire logic [31:0]         o_sync_time,
    input wire logic                o_free_running,
    input wire sync_sel_pkg::stat_t o_sat_status,
    input wire sync_sel_pkg::stat_t o_radio_status,
    input wire sync_sel_pkg::stat_t o_serial_status
);
    logic       code_ok, sat_pair, multi, safe;
    logic [1:0] oth_src, prim_src, sec_src, prim_st, sec_st;
    assign code_ok  = (i_mode <= 4'hA) && (i_mode != 4'h1) && (i_mode != 4'h5) && (i_mode != 4'h8);
    assign sat_pair = (o_mode == 4'h9);
    assign multi    = sat_pair || (o_mode == 4'hA);
    assign safe     = (o_mode == 4'h6) || (o_mode == 4'h7);
    assign oth_src  = sat_pair ? 2'h1 : 2'h2;
    assign prim_src = i_serial_primary ? 2'h3 : oth_src;
    assign sec_src  = i_serial_primary ? oth_src : 2'h3;
    assign prim_st  = i_serial_primary ? o_serial_status : (sat_pair ? o_sat_status : o_radio_status);
    assign sec_st   = i_serial_primary ? (sat_pair ? o_sat_status : o_radio_status) : o_serial_status;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);
    ////////////////////////////////////////////////////////////////////////////////
    property p_refuse; i_mode_load && !code_ok |=> o_mode_refused && (o_mode == $past(o_mode)); endproperty
    a_refuse: assert property (p_refuse) else $error("refused code changed mode");
    property p_accept; i_mode_load && code_ok |=> !o_mode_refused && (o_mode == $past(i_mode)); endproperty
    a_accept: assert property (p_accept) else $error("mode code not applied");
    property p_trim; i_quartz_load |=> o_quartz_value == $past(i_quartz_value); endproperty
    a_trim: assert property (p_trim) else $error("quartz value not loaded");
    property p_trim_hold; !i_quartz_load |=> $stable(o_quartz_value); endproperty
    a_trim_hold: assert property (p_trim_hold) else $error("quartz value drifted");
    property p_free; (o_mode == 4'h0) [*6] |-> (o_active_src == 2'h0) && !o_sync_pulse && o_free_running; endproperty
    a_free: assert property (p_free) else $error("free run took a source");
    property p_safe; safe && (o_mode == $past(o_mode, 6)) && o_sync_pulse |-> o_sync_time == i_serial_time; endproperty
    a_safe: assert property (p_safe) else $error("safety time not the string time");
    property p_keep;
        multi && (o_mode == $past(o_mode, 3)) && (i_serial_primary == $past(i_serial_primary, 3))
            && ($past(prim_st) == 2'h2) |-> o_active_src == prim_src;
    endproperty
    a_keep: assert property (p_keep) else $error("synced primary not used");
    property p_fallback;
        multi && (o_mode == $past(o_mode, 3)) && (i_serial_primary == $past(i_serial_primary, 3))
            && ($past(prim_st) != 2'h2) && ($past(sec_st) == 2'h2) |-> o_active_src == sec_src;
    endproperty
    a_fallback: assert property (p_fallback) else $error("no fallback to secondary");
    property p_none;
        multi && (o_mode == $past(o_mode, 3)) && ($past(prim_st) != 2'h2) && ($past(sec_st) != 2'h2)
            |-> o_free_running;
    endproperty
    a_none: assert property (p_none) else $error("no synced source yet not free running");
endmodule
bind sync_source_selector sync_source_selector_asserts u_sync_source_selector_asserts (
    .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_mode(i_mode), .i_mode_load(i_mode_load),
    .i_serial_primary(i_serial_primary), .i_quartz_value(i_quartz_value), .i_quartz_load(i_quartz_load),
    .i_serial_time(i_serial_time), .o_mode(o_mode), .o_mode_refused(o_mode_refused),
    .o_quartz_value(o_quartz_value), .o_active_src(o_active_src), .o_sync_pulse(o_sync_pulse),
    .o_sync_time(o_sync_time), .o_free_running(o_free_running), .o_sat_status(o_sat_status),
    .o_radio_status(o_radio_status), .o_serial_status(o_serial_status));

// *** verif/tb_time_sync_source_selector.sv ***
// self-checking bench of the sync source selector
`timescale 1ns/10ps
module tb_time_sync_source_selector;
    logic                i_ref_clk, i_resetn, i_mode_load, i_serial_primary, i_quartz_load, skew;
    logic [3:0]          i_mode, tag;
    logic [15:0]         i_quartz_value, o_quartz_value;
    logic [31:0]         inf, rnd, o_sync_time, sat_t, sat_i, rad_t, rad_i, ser_t, ser_i;
    logic [31:0]         tm = 32'h59;
    logic [3:0]          tcnt = 4'h0;
    logic                tick = 1'b0;
    logic [2:0]          run, lck;
    logic                o_mode_refused, o_sync_pulse, o_discipline, o_free_running, o_mismatch;
    logic                o_disp_primary_mark, sat_ev, sat_lk, rad_ev, rad_lk, ser_ev, ser_lk;
    sync_sel_pkg::mode_t o_mode;
    sync_sel_pkg::src_t  o_active_src;
    sync_sel_pkg::disp_t o_disp_id;
    sync_sel_pkg::stat_t o_sat_status, o_radio_status, o_serial_status;
    int                  mismatches, tests_run;
    sync_source_selector #(.TIMEOUT(50), .ALT_CYC(8)) u_sync_source_selector (
        .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_mode(i_mode), .i_mode_load(i_mode_load),
        .i_serial_primary(i_serial_primary), .i_quartz_value(i_quartz_value), .i_quartz_load(i_quartz_load),
        .i_sat_event(sat_ev), .i_sat_locked(sat_lk), .i_sat_time(sat_t), .i_sat_info(sat_i),
        .i_radio_pulse(rad_ev), .i_radio_locked(rad_lk), .i_radio_time(rad_t), .i_radio_info(rad_i),
        .i_serial_event(ser_ev), .i_serial_locked(ser_lk), .i_serial_time(ser_t), .i_serial_info(ser_i),
        .o_mode(o_mode), .o_mode_refused(o_mode_refused), .o_quartz_value(o_quartz_value),
        .o_active_src(o_active_src), .o_sync_pulse(o_sync_pulse), .o_sync_time(o_sync_time),
        .o_discipline(o_discipline), .o_free_running(o_free_running), .o_mismatch(o_mismatch),
        .o_disp_id(o_disp_id), .o_disp_primary_mark(o_disp_primary_mark), .o_sat_status(o_sat_status),
        .o_radio_status(o_radio_status), .o_serial_status(o_serial_status));
    src_model u_sat (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_run(run[0]), .i_lock(lck[0]), .i_tick(tick),
        .i_time(tm), .i_info(inf), .o_event(sat_ev), .o_locked(sat_lk), .o_time(sat_t), .o_info(sat_i));
    src_model u_rad (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_run(run[1]), .i_lock(lck[1]), .i_tick(tick),
        .i_time(tm), .i_info(inf), .o_event(rad_ev), .o_locked(rad_lk), .o_time(rad_t), .o_info(rad_i));
    src_model u_ser (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_run(run[2]), .i_lock(lck[2]), .i_tick(tick),
        .i_time(tm), .i_info(inf ^ {31'h0, skew}), .o_event(ser_ev), .o_locked(ser_lk), .o_time(ser_t),
        .o_info(ser_i));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] r;
        r = v ^ (v << 13);
        r = r ^ (r >> 17);
        return r ^ (r << 5);
    endfunction
    function automatic logic ok(input logic [3:0] c);
        return (c <= 4'hA) && (c != 4'h1) && (c != 4'h5) && (c != 4'h8);
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        if (mismatches == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge i_ref_clk);
    endtask
    task automatic load(input logic [3:0] c);
        i_mode = c;
        i_mode_load = 1'b1;
        @(negedge i_ref_clk);
    endtask
    task automatic wait_pulse;
        int n;
        n = 0;
        while (o_sync_pulse !== 1'b1) begin
            @(negedge i_ref_clk);
            n++;
            if (n > 200) begin
                check(32'h0, 32'h1);
                report_and_stop;
            end
        end
    endtask
    task automatic count(input int n, output int hits, output int marks);
        hits = 0;
        marks = 0;
        repeat (n) begin
            @(negedge i_ref_clk);
            if (o_sync_pulse === 1'b1) hits++;
            if (o_disp_primary_mark === 1'b1) begin
                marks++;
                check(o_disp_id, tag);
            end
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        i_ref_clk = 1'b0;
        forever #2.5 i_ref_clk = ~i_ref_clk;
    end
    always @(negedge i_ref_clk) begin
        tcnt <= tcnt + 4'h1;
        tick <= (tcnt == 4'hF);
        if (tcnt == 4'hF) tm <= xs(tm);
    end
    initial begin
        int c, e, m, p, s, k;
        logic [15:0] q;
        {i_resetn, i_mode_load, i_serial_primary, i_quartz_load, skew} = 5'h0;
        {i_mode, tag, i_quartz_value, run, lck} = 30'h0;
        {mismatches, tests_run} = 64'h0;
        rnd = 32'h59;
        inf = xs(rnd);
        cyc(12);
        i_resetn = 1'b1;
        cyc(1);
        check(o_quartz_value, 32'h8000);
        check(o_active_src, 32'h0);
        check(o_free_running, 32'h1);
        e = 0;
        for (c = 0; c < 16; c++) begin
            load(c[3:0]);
            if (ok(c[3:0])) e = c;
            check(o_mode, e);
            check(o_mode_refused, !ok(c[3:0]));
        end
        for (k = 0; k < 4; k++) begin
            rnd = xs(rnd);
            q = (k == 0) ? 16'h0000 : (k == 1) ? 16'hFFFF : rnd[15:0];
            i_quartz_value = q;
            i_quartz_load = 1'b1;
            @(negedge i_ref_clk);
            check(o_quartz_value, q);
        end
        i_quartz_load = 1'b0;
        run = 3'h7;
        lck = 3'h7;
        load(4'h0);
        i_mode_load = 1'b0;
        count(60, k, e);
        check(k, 32'h0);
        check(o_quartz_value, q);
        check(o_sat_status, 32'h2);
        for (m = 2; m < 5; m++) begin
            load(m[3:0]);
            i_mode_load = 1'b0;
            cyc(8);
            wait_pulse;
            check(o_active_src, m - 1);
            check(o_sync_time, tm);
            check(o_discipline, 32'h1);
        end
        lck[0] = 1'b0;
        cyc(40);
        check(o_sat_status, 32'h1);
        run[0] = 1'b0;
        cyc(80);
        check(o_sat_status, 32'h0);
        run[0] = 1'b1;
        lck[0] = 1'b1;
        load(4'h6);
        i_mode_load = 1'b0;
        cyc(8);
        wait_pulse;
        check(o_sync_time, tm);
        check(o_mismatch, 32'h0);
        skew = 1'b1;
        cyc(20);
        count(40, k, e);
        check(k, 32'h0);
        check(o_mismatch, 32'h1);
        skew = 1'b0;
        load(4'h7);
        i_mode_load = 1'b0;
        cyc(8);
        wait_pulse;
        check(o_sync_time, tm);
        run[2] = 1'b0;
        cyc(80);
        count(40, k, e);
        check(k, 32'h0);
        for (k = 0; k < 4; k++) begin
            run = 3'h7;
            lck = 3'h7;
            i_serial_primary = k[0];
            m = k[1] ? 2 : 1;
            p = k[0] ? 3 : m;
            s = k[0] ? m : 3;
            tag = 4'(p + 5);
            load(k[1] ? 4'hA : 4'h9);
            i_mode_load = 1'b0;
            cyc(30);
            count(40, c, e);
            check(o_active_src, p);
            check((e > 0) && (e < 40), 32'h1);
            lck[p - 1] = 1'b0;
            cyc(40);
            check(o_active_src, s);
            lck[s - 1] = 1'b0;
            cyc(40);
            check(o_free_running, 32'h1);
        end
        report_and_stop;
    end
endmodule
